// ---- core/jtf_pkg.sv ----
// Constants, tables and types shared by the serial link framer
package jtf_pkg;

  // Link shape
  localparam int JTF_NUM_CONV = 4;
  localparam int JTF_SMP_BITS = 16;
  localparam int JTF_OCT_MAX = 8;
  localparam int JTF_LANES = 4;
  localparam int JTF_MAP_BITS = 2;

  // Lane modes: one, two or four lanes
  localparam logic [1:0] JTF_MODE_L1 = 2'h0;
  localparam logic [1:0] JTF_MODE_L2 = 2'h1;
  localparam logic [1:0] JTF_MODE_L4 = 2'h2;

  // Register offsets
  localparam logic [7:0] JTF_ADDR_CTRL = 8'h00;
  localparam logic [7:0] JTF_ADDR_MAP = 8'h04;
  localparam logic [7:0] JTF_ADDR_STATUS = 8'h08;
  localparam logic [7:0] JTF_ADDR_FCHK = 8'h0C;

  // Control fields and reset values
  localparam int JTF_CTRL_DIS_BIT = 0;
  localparam int JTF_CTRL_SCR_BIT = 1;
  localparam int JTF_CTRL_MODE_LSB = 2;
  localparam int JTF_CTRL_KM1_LSB = 8;
  localparam logic [4:0] JTF_KM1_RST = 5'h1F;
  localparam logic [7:0] JTF_MAP_RST = 8'hE4;

  // Status fields
  localparam int JTF_STAT_STATE_LSB = 0;
  localparam int JTF_STAT_SREQ_BIT = 4;
  localparam int JTF_STAT_REALIGN_BIT = 5;
  localparam int JTF_STAT_FCHK_LSB = 8;

  // Start-up timing, in frame clocks, multiframes and octets
  localparam int JTF_TOGGLE_FRAMES = 13;
  localparam int JTF_CGS_LMFC_MIN = 4;
  localparam int JTF_CGS_LMFC_REALIGN = 6;
  localparam int JTF_ILAS_START_BND = 2;
  localparam int JTF_ILAS_MF = 4;
  localparam int JTF_ILAS_CFG_MF = 1;
  localparam int JTF_CFG_FIRST = 2;
  localparam int JTF_CFG_OCTETS = 14;

  // Control characters
  localparam logic [7:0] JTF_K28_0 = 8'h1C;
  localparam logic [7:0] JTF_K28_3 = 8'h7C;
  localparam logic [7:0] JTF_K28_4 = 8'h9C;
  localparam logic [7:0] JTF_K28_5 = 8'hBC;
  localparam logic [7:0] JTF_K28_7 = 8'hFC;
  localparam logic [9:0] JTF_TOGGLE_SYM = 10'h2AA;

  // Link parameter fields; identity values are arbitrary
  localparam logic [7:0] JTF_DID = 8'h5A;
  localparam logic [3:0] JTF_BID = 4'h3;
  localparam logic [7:0] JTF_M_M1 = 8'h03;
  localparam logic [4:0] JTF_N_M1 = 5'h0F;
  localparam logic [4:0] JTF_NP_M1 = 5'h0F;
  localparam logic [4:0] JTF_S_M1 = 5'h00;
  localparam logic [1:0] JTF_CS = 2'h0;
  localparam logic [4:0] JTF_CF = 5'h00;
  localparam logic JTF_HD = 1'b0;
  localparam logic [2:0] JTF_SUBCLASS = 3'h1;
  localparam logic [2:0] JTF_JESDV = 3'h1;

  // 8b/10b tables, running disparity negative, first bit sent in the MSB
  localparam logic [31:0][5:0] JTF_TAB6 = {
    6'h2B, 6'h1E, 6'h2E, 6'h0E, 6'h36, 6'h16, 6'h26, 6'h33,
    6'h3A, 6'h1A, 6'h2A, 6'h0B, 6'h32, 6'h13, 6'h23, 6'h1B,
    6'h17, 6'h1C, 6'h2C, 6'h0D, 6'h34, 6'h15, 6'h25, 6'h39,
    6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2D, 6'h1D, 6'h27};
  localparam logic [7:0][3:0] JTF_TAB4 = {
    4'hE, 4'h6, 4'hA, 4'hD, 4'hC, 4'h5, 4'h9, 4'hB};
  localparam logic [3:0] JTF_ALT7 = 4'h7;
  localparam logic [5:0] JTF_K28_6B = 6'h0F;
  localparam logic [4:0] JTF_X7 = 5'h07;
  localparam logic [2:0] JTF_Y3 = 3'h3;
  localparam logic [2:0] JTF_Y7 = 3'h7;

  typedef enum logic [2:0] {
    JTF_ST_OFF,
    JTF_ST_TOGGLE,
    JTF_ST_CGS,
    JTF_ST_ILAS,
    JTF_ST_DATA
  } jtf_state_type;

  typedef struct packed {
    logic [JTF_NUM_CONV-1:0][JTF_SMP_BITS-1:0] conv;
  } jtf_samples_type;

  typedef struct packed {
    logic active;
    logic [3:0] count;
    logic [JTF_OCT_MAX-1:0][9:0] sym;
  } jtf_lane_type;

endpackage

// ---- core/jtf_link_framer.sv ----
// Transmit link layer: framing, scrambling, 8b/10b, replacement and start-up
// Operation
// - Four converters per link, one sample each per frame clock.
// - One, two or four lanes with eight, four or two octets per frame.
// - Samples are 16 bits resolution and 16 bits on the link.
// - Zero control words, zero control bits, high density off.
// - Frames per multiframe and scrambler enable are programmable.
// - Link parameter checksum computed here and readable by software.
// - Reset configuration is four converters on one lane.
// - Two-lane mode packs two converters onto each lane.
// - Converter to link position mapping is programmable.
// - Sample split into two octets, most significant half first.
// - Optional self-synchronizing scrambler, polynomial 1 + x^14 + x^15.
// - Every octet is 8b/10b encoded into one 10-bit symbol.
// - Unscrambled: multiframe end repeating previous octet becomes K28.3.
// - Unscrambled: other frame end repeating previous octet becomes K28.7.
// - Scrambled: multiframe end octet 0x7C is sent as K28.3.
// - Scrambled: other frame end octet 0xFC is sent as K28.7.
// - After serializer lock each active lane sends alternating ones and zeros.
// - Thirteen frames later send K28.5 and start the multiframe clock.
// - Sync request held four multiframes, six with realignment, starts sync.
// - Lane alignment starts on second multiframe boundary after release.
// - Scrambling only in data phase, never in sync or alignment.
`timescale 1ns/1ns
module jtf_link_framer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Converter samples, one set per frame clock
  input wire jtf_pkg::jtf_samples_type samples,
  // Link control pins
  input wire logic serializer_ready,
  input wire logic link_sync_request_n,
  input wire logic sysref,
  // Lane symbols and state
  output jtf_pkg::jtf_lane_type lanes [jtf_pkg::JTF_LANES],
  output jtf_pkg::jtf_state_type link_state
);
  import jtf_pkg::*;

  // Pin synchronisers
  logic [1:0] rdy_sync_r;
  logic [1:0] sreq_sync_r;
  logic [1:0] sysref_sync_r;
  logic sysref_prev_r;
  logic ser_ready;
  logic sync_req;
  logic sysref_edge;

  // Configuration
  logic link_dis_r;
  logic scr_en_r;
  logic [1:0] mode_r;
  logic [4:0] km1_r;
  logic [7:0] map_r;
  logic [7:0] fchk_r;
  logic [31:0] rdata_r;

  // Sequencing
  jtf_state_type state_r;
  jtf_state_type state_nxt;
  logic [3:0] tog_cnt_r;
  logic [4:0] frame_cnt_r;
  logic [1:0] bnd_cnt_r;
  logic [2:0] req_cnt_r;
  logic realign_r;
  logic [1:0] ilas_mf_r;
  logic [7:0] ramp_r;

  logic [3:0] f_oct;
  logic [2:0] n_lanes;
  logic lmfc_last;
  logic cgs_req_met;
  logic [8:0] mf_last_p;
  logic [JTF_OCT_MAX-1:0][7:0] oct;

  // Scrambler: S(n) = D(n) ^ S(n-14) ^ S(n-15), MSB first
  function automatic logic [22:0] jtf_scr(input logic [14:0] st, input logic [7:0] d);
    logic [14:0] s;
    logic [7:0] o;
    s = st;
    o = '0;
    for (int b = 7; b >= 0; b--) begin
      o[b] = d[b] ^ s[13] ^ s[14];
      s = {s[13:0], o[b]};
    end
    return {s, o};
  endfunction

  // 8b/10b encoder; returns {running disparity out, symbol}; only K28.y control codes
  function automatic logic [10:0] jtf_enc(input logic [7:0] d, input logic k, input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] c6;
    logic [3:0] c4;
    logic rd_m;
    logic alt;
    x = d[4:0];
    y = d[7:5];
    c6 = k ? JTF_K28_6B : JTF_TAB6[x];
    if (rd && (($countones(c6) != 3) || (!k && x == JTF_X7))) begin
      c6 = ~c6;
    end
    rd_m = ($countones(c6) != 3) ? ~rd : rd;
    c4 = JTF_TAB4[y];
    // Alternate code avoids a run of five in the data cases that would make one; K28.7 always takes it
    alt = (y == JTF_Y7) && (k || (!rd_m && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
          (rd_m && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
    if (alt) begin
      c4 = JTF_ALT7;
    end
    if (rd_m && (($countones(c4) != 2) || y == JTF_Y3)) begin
      c4 = ~c4;
    end else if (k && !rd_m && ($countones(c4) == 2) && y != JTF_Y3) begin
      c4 = ~c4;
    end
    return {(($countones(c4) != 2) ? ~rd_m : rd_m), c6, c4};
  endfunction

  // Link parameter checksum over all fields, per lane
  function automatic logic [7:0] jtf_fchk(input logic [1:0] lane, input logic scr,
                                          input logic [1:0] mode, input logic [4:0] km1);
    int sum;
    sum = 0;
    sum = JTF_DID + JTF_BID + lane + scr + ((1 << mode) - 1) + ((JTF_OCT_MAX >> mode) - 1);
    sum = sum + km1 + JTF_M_M1 + JTF_N_M1 + JTF_CS + JTF_NP_M1 + JTF_SUBCLASS;
    sum = sum + JTF_S_M1 + JTF_JESDV + JTF_CF + JTF_HD;
    return 8'(sum);
  endfunction

  // Configuration octets sent in the second alignment multiframe
  function automatic logic [7:0] jtf_cfg(input logic [3:0] idx, input logic [1:0] lane,
                                         input logic scr, input logic [1:0] mode,
                                         input logic [4:0] km1);
    logic [7:0] v;
    v = '0;
    case (idx)
      4'h0: v = JTF_DID;
      4'h1: v = {4'h0, JTF_BID};
      4'h2: v = {6'h00, lane};
      4'h3: v = {scr, 2'h0, 5'((1 << mode) - 1)};
      4'h4: v = 8'((JTF_OCT_MAX >> mode) - 1);
      4'h5: v = {3'h0, km1};
      4'h6: v = JTF_M_M1;
      4'h7: v = {JTF_CS, 1'b0, JTF_N_M1};
      4'h8: v = {JTF_SUBCLASS, JTF_NP_M1};
      4'h9: v = {JTF_JESDV, JTF_S_M1};
      4'hA: v = {JTF_HD, 2'h0, JTF_CF};
      4'hD: v = jtf_fchk(lane, scr, mode, km1);
      default: v = '0;
    endcase
    return v;
  endfunction

  // Two flops on every pin before use; sync request resets to asserted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdy_sync_r <= '0;
      sreq_sync_r <= '0;
      sysref_sync_r <= '0;
      sysref_prev_r <= 1'b0;
    end else begin
      rdy_sync_r <= {rdy_sync_r[0], serializer_ready};
      sreq_sync_r <= {sreq_sync_r[0], link_sync_request_n};
      sysref_sync_r <= {sysref_sync_r[0], sysref};
      sysref_prev_r <= sysref_sync_r[1];
    end
  end

  assign ser_ready = rdy_sync_r[1];
  assign sync_req = ~sreq_sync_r[1];
  assign sysref_edge = sysref_sync_r[1] & ~sysref_prev_r;

  // Register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_dis_r <= 1'b0;
      scr_en_r <= 1'b0;
      mode_r <= JTF_MODE_L1;
      km1_r <= JTF_KM1_RST;
      map_r <= JTF_MAP_RST;
    end else if (reg_wr) begin
      if (reg_addr == JTF_ADDR_CTRL) begin
        link_dis_r <= reg_wdata[JTF_CTRL_DIS_BIT];
        scr_en_r <= reg_wdata[JTF_CTRL_SCR_BIT];
        km1_r <= reg_wdata[JTF_CTRL_KM1_LSB +: 5];
        // Unused mode code falls back to four lanes
        if (reg_wdata[JTF_CTRL_MODE_LSB +: 2] > JTF_MODE_L4) begin
          mode_r <= JTF_MODE_L4;
        end else begin
          mode_r <= reg_wdata[JTF_CTRL_MODE_LSB +: 2];
        end
      end
      if (reg_addr == JTF_ADDR_MAP) begin
        map_r <= reg_wdata[7:0];
      end
    end
  end

  // Checksum tracks the live settings
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fchk_r <= '0;
    end else begin
      fchk_r <= jtf_fchk(2'h0, scr_en_r, mode_r, km1_r);
    end
  end

  // Register reads; data stands for one cycle only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= '0;
      if (reg_rd) begin
        case (reg_addr)
          JTF_ADDR_CTRL: begin
            rdata_r[JTF_CTRL_DIS_BIT] <= link_dis_r;
            rdata_r[JTF_CTRL_SCR_BIT] <= scr_en_r;
            rdata_r[JTF_CTRL_MODE_LSB +: 2] <= mode_r;
            rdata_r[JTF_CTRL_KM1_LSB +: 5] <= km1_r;
          end
          JTF_ADDR_MAP: rdata_r[7:0] <= map_r;
          JTF_ADDR_STATUS: begin
            rdata_r[JTF_STAT_STATE_LSB +: 3] <= state_r;
            rdata_r[JTF_STAT_SREQ_BIT] <= sync_req;
            rdata_r[JTF_STAT_REALIGN_BIT] <= realign_r;
            rdata_r[JTF_STAT_FCHK_LSB +: 8] <= fchk_r;
          end
          JTF_ADDR_FCHK: rdata_r[7:0] <= fchk_r;
          default: rdata_r <= '0;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_r;

  // Lane geometry: total octets per frame clock stays eight
  assign f_oct = 4'(JTF_OCT_MAX >> mode_r);
  assign n_lanes = 3'(1 << mode_r);
  assign lmfc_last = (frame_cnt_r == km1_r);
  assign mf_last_p = 9'((km1_r + 1) * f_oct - 1);
  assign cgs_req_met = realign_r ? (req_cnt_r >= 3'(JTF_CGS_LMFC_REALIGN)) :
                       (req_cnt_r >= 3'(JTF_CGS_LMFC_MIN));

  // Sample mapping and octet split, upper half sent first
  for (genvar p = 0; p < JTF_NUM_CONV; p++) begin : g_map
    logic [1:0] src;
    assign src = map_r[p*JTF_MAP_BITS +: JTF_MAP_BITS];
    assign oct[2*p] = samples.conv[src][15:8];
    assign oct[2*p+1] = samples.conv[src][7:0];
  end

  // Start-up sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      JTF_ST_OFF: begin
        if (ser_ready) begin
          state_nxt = JTF_ST_TOGGLE;
        end
      end
      JTF_ST_TOGGLE: begin
        if (tog_cnt_r == 4'(JTF_TOGGLE_FRAMES - 1)) begin
          state_nxt = JTF_ST_CGS;
        end
      end
      JTF_ST_CGS: begin
        // Leave on the frame before the second boundary after release
        if (!sync_req && bnd_cnt_r == 2'(JTF_ILAS_START_BND - 1) && lmfc_last) begin
          state_nxt = JTF_ST_ILAS;
        end
      end
      JTF_ST_ILAS: begin
        if (lmfc_last && ilas_mf_r == 2'(JTF_ILAS_MF - 1)) begin
          state_nxt = JTF_ST_DATA;
        end
      end
      JTF_ST_DATA: state_nxt = JTF_ST_DATA;
      default: state_nxt = JTF_ST_OFF;
    endcase
    if ((state_r == JTF_ST_ILAS || state_r == JTF_ST_DATA) && cgs_req_met) begin
      state_nxt = JTF_ST_CGS;
    end
    // Disable holds the link in reset while it is reconfigured
    if (link_dis_r || !ser_ready) begin
      state_nxt = JTF_ST_OFF;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= JTF_ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign link_state = state_r;

  // Toggle phase length
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_cnt_r <= '0;
    end else if (state_r == JTF_ST_TOGGLE) begin
      tog_cnt_r <= tog_cnt_r + 4'h1;
    end else begin
      tog_cnt_r <= '0;
    end
  end

  // Local multiframe clock; SYSREF realigns it, runs from K28.5 onward
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_cnt_r <= '0;
    end else if (state_r == JTF_ST_OFF || state_r == JTF_ST_TOGGLE) begin
      frame_cnt_r <= '0;
    end else if (sysref_edge || lmfc_last) begin
      frame_cnt_r <= '0;
    end else begin
      frame_cnt_r <= frame_cnt_r + 5'h01;
    end
  end

  // Boundaries seen since the request was released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bnd_cnt_r <= '0;
    end else if (state_r != JTF_ST_CGS || sync_req) begin
      bnd_cnt_r <= '0;
    end else if (lmfc_last && bnd_cnt_r != 2'(JTF_ILAS_START_BND)) begin
      bnd_cnt_r <= bnd_cnt_r + 2'h1;
    end
  end

  // Multiframes of held request, and whether SYSREF realigned meanwhile
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_cnt_r <= '0;
      realign_r <= 1'b0;
    end else if (!sync_req || state_r == JTF_ST_CGS) begin
      req_cnt_r <= '0;
      realign_r <= 1'b0;
    end else begin
      if (lmfc_last && req_cnt_r != 3'(JTF_CGS_LMFC_REALIGN)) begin
        req_cnt_r <= req_cnt_r + 3'h1;
      end
      if (sysref_edge) begin
        realign_r <= 1'b1;
      end
    end
  end

  // Alignment multiframe index and ramp, ramp keeps rising across multiframes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ilas_mf_r <= '0;
      ramp_r <= '0;
    end else if (state_r != JTF_ST_ILAS) begin
      ilas_mf_r <= '0;
      ramp_r <= '0;
    end else begin
      ramp_r <= ramp_r + 8'(f_oct);
      if (lmfc_last) begin
        ilas_mf_r <= ilas_mf_r + 2'h1;
      end
    end
  end

  // Per-lane octet selection, scrambling, replacement and encoding
  for (genvar l = 0; l < JTF_LANES; l++) begin : g_lane
    logic [14:0] scr_st_r;
    logic [14:0] scr_st_nxt;
    logic rd_r;
    logic rd_nxt;
    logic [7:0] prev_last_r;
    logic [7:0] prev_last_nxt;
    logic [JTF_OCT_MAX-1:0][9:0] sym_nxt;
    jtf_lane_type lane_r;

    always_comb begin
      logic [14:0] st;
      logic rd;
      logic [7:0] d;
      logic kf;
      logic [2:0] pos;
      logic [8:0] p;
      logic [22:0] sr;
      logic [10:0] en;
      st = scr_st_r;
      rd = rd_r;
      d = '0;
      kf = 1'b0;
      pos = '0;
      p = '0;
      sr = '0;
      en = '0;
      prev_last_nxt = prev_last_r;
      sym_nxt = '0;
      for (int j = 0; j < JTF_OCT_MAX; j++) begin
        if (l < n_lanes && j < f_oct) begin
          pos = 3'(l * f_oct + j);
          p = 9'(frame_cnt_r * f_oct + j);
          d = oct[pos];
          kf = 1'b0;
          case (state_r)
            JTF_ST_CGS: begin
              d = JTF_K28_5;
              kf = 1'b1;
            end
            JTF_ST_ILAS: begin
              // No scrambling while aligning
              kf = 1'b1;
              if (p == '0) begin
                d = JTF_K28_0;
              end else if (p == mf_last_p) begin
                d = JTF_K28_3;
              end else if (ilas_mf_r == 2'(JTF_ILAS_CFG_MF) && p == 9'h001) begin
                d = JTF_K28_4;
              end else if (ilas_mf_r == 2'(JTF_ILAS_CFG_MF) && p >= 9'(JTF_CFG_FIRST) &&
                           p < 9'(JTF_CFG_FIRST + JTF_CFG_OCTETS)) begin
                d = jtf_cfg(4'(p - JTF_CFG_FIRST), 2'(l), scr_en_r, mode_r, km1_r);
                kf = 1'b0;
              end else begin
                d = ramp_r + 8'(j);
                kf = 1'b0;
              end
            end
            JTF_ST_DATA: begin
              if (scr_en_r) begin
                sr = jtf_scr(st, d);
                st = sr[22:8];
                d = sr[7:0];
              end
              if (j == f_oct - 1) begin
                if (scr_en_r) begin
                  // Control codes share the octet value, so only the K flag changes
                  kf = lmfc_last ? (d == JTF_K28_3) : (d == JTF_K28_7);
                end else if (d == prev_last_r) begin
                  d = lmfc_last ? JTF_K28_3 : JTF_K28_7;
                  kf = 1'b1;
                end
                prev_last_nxt = oct[pos];
              end
            end
            default: d = '0;
          endcase
          if (state_r == JTF_ST_TOGGLE) begin
            sym_nxt[j] = JTF_TOGGLE_SYM;
          end else if (state_r != JTF_ST_OFF) begin
            en = jtf_enc(d, kf, rd);
            rd = en[10];
            sym_nxt[j] = en[9:0];
          end
        end
      end
      scr_st_nxt = st;
      rd_nxt = rd;
    end

    // Disparity restarts negative whenever the link is off
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        scr_st_r <= '0;
        rd_r <= 1'b0;
        prev_last_r <= '0;
      end else if (state_r == JTF_ST_OFF) begin
        scr_st_r <= '0;
        rd_r <= 1'b0;
        prev_last_r <= '0;
      end else begin
        scr_st_r <= scr_st_nxt;
        rd_r <= rd_nxt;
        prev_last_r <= prev_last_nxt;
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        lane_r <= '0;
      end else begin
        lane_r.active <= (l < n_lanes) && (state_r != JTF_ST_OFF);
        lane_r.count <= (l < n_lanes) ? f_oct : 4'h0;
        lane_r.sym <= sym_nxt;
      end
    end

    assign lanes[l] = lane_r;
  end

endmodule

// ---- tb/jtf_link_framer_checker.sv ----
// Concurrent checks on the serial link framer ports
`timescale 1ns/1ns
module jtf_link_framer_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Link pins and lanes
  input wire logic serializer_ready,
  input wire logic link_sync_request_n,
  input jtf_pkg::jtf_lane_type lanes [jtf_pkg::JTF_LANES],
  input jtf_pkg::jtf_state_type link_state
);
  import jtf_pkg::*;
  logic [4:0] km1_r;
  logic [11:0] held_r;
  // Frame count per multiframe is shadowed from writes; the checker cannot read back
  always_ff @(posedge clk or posedge rst) begin
    if (rst) km1_r <= JTF_KM1_RST;
    else if (reg_wr && reg_addr == JTF_ADDR_CTRL) km1_r <= reg_wdata[12:8];
  end
  // Saturates so a long hold from power-up never wraps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) held_r <= 12'h000;
    else if (link_sync_request_n) held_r <= 12'h000;
    else if (held_r != 12'hFFF) held_r <= held_r + 12'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Judged at the hand-over to sync, so a toggle cut short by a disable is not flagged
  property p_toggle_len;
    link_state == JTF_ST_CGS && $past(link_state) == JTF_ST_TOGGLE
      |-> $past(link_state, 13) == JTF_ST_TOGGLE && $past(link_state, 14) == JTF_ST_OFF;
  endproperty
  a_toggle_len: assert property (p_toggle_len) else $error("toggle length");
  property p_toggle_sym;
    $past(link_state) == JTF_ST_TOGGLE |-> lanes[0].sym[0] == JTF_TOGGLE_SYM;
  endproperty
  a_toggle_sym: assert property (p_toggle_sym) else $error("toggle symbol");
  property p_cgs_k;
    $past(link_state) == JTF_ST_CGS |-> lanes[0].sym[0] inside {10'h0FA, 10'h305};
  endproperty
  a_cgs_k: assert property (p_cgs_k) else $error("sync symbol");
  property p_count;
    lanes[0].active |-> lanes[0].count inside {4'h8, 4'h4, 4'h2};
  endproperty
  a_count: assert property (p_count) else $error("octet count");
  property p_one_lane;
    lanes[0].active && lanes[0].count == 4'h8 |-> !lanes[1].active;
  endproperty
  a_one_lane: assert property (p_one_lane) else $error("extra lane");
  property p_ilas_wait;
    (link_state == JTF_ST_CGS && !link_sync_request_n) [*3] |=> link_state != JTF_ST_ILAS;
  endproperty
  a_ilas_wait: assert property (p_ilas_wait) else $error("early alignment");
  property p_resync;
    $past(link_state) == JTF_ST_DATA && link_state == JTF_ST_CGS
      |-> held_r > 12'h003 * ({7'h00, km1_r} + 12'h001);
  endproperty
  a_resync: assert property (p_resync) else $error("early resync");
  property p_ser_off;
    !serializer_ready [*4] |=> link_state == JTF_ST_OFF;
  endproperty
  a_ser_off: assert property (p_ser_off) else $error("not off");
endmodule
bind jtf_link_framer jtf_link_framer_checker u_chk (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .serializer_ready(serializer_ready), .link_sync_request_n(link_sync_request_n),
  .lanes(lanes), .link_state(link_state));

// ---- tb/jtf_rx_model.sv ----
// Behavioural link receiver driving sync request and SYSREF
`timescale 1ns/1ns
module jtf_rx_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Lane 0 symbol and bench command
  input wire logic [9:0] sym0,
  input wire logic resync,
  // Link control pins
  output logic link_sync_request_n,
  output logic sysref
);
  logic [4:0] kcnt_r;
  logic [9:0] hold_r;
  // Hold of 400 clocks covers six multiframes of 32 frames after SYSREF
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_sync_request_n <= 1'b0;
      sysref <= 1'b0;
      kcnt_r <= 5'h00;
      hold_r <= 10'h000;
    end else if (resync) begin
      link_sync_request_n <= 1'b0;
      kcnt_r <= 5'h00;
      hold_r <= 10'h000;
    end else if (!link_sync_request_n) begin
      if (kcnt_r != 5'h10) kcnt_r <= (sym0 == 10'h0FA || sym0 == 10'h305) ? kcnt_r + 5'h01 : 5'h00;
      else hold_r <= hold_r + 10'h001;
      sysref <= hold_r >= 10'h002 && hold_r < 10'h006;
      if (hold_r == 10'h190) link_sync_request_n <= 1'b1;
    end
  end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the serial link framer
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
  import jtf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  jtf_samples_type samples = '0;
  logic serializer_ready = 1'b0;
  logic resync = 1'b0;
  logic link_sync_request_n;
  logic sysref;
  jtf_lane_type lanes [JTF_LANES];
  jtf_state_type link_state;
  int miscompares = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  jtf_link_framer dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .samples(samples),
    .serializer_ready(serializer_ready), .link_sync_request_n(link_sync_request_n),
    .sysref(sysref), .lanes(lanes), .link_state(link_state));
  jtf_rx_model u_rx (.clk(clk), .rst(rst), .sym0(lanes[0].sym[0]), .resync(resync),
    .link_sync_request_n(link_sync_request_n), .sysref(sysref));
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic wait_for(input jtf_state_type s, input int n);
    int i;
    for (i = 0; i < n && link_state !== s; i++) begin
      @(posedge clk);
      #1;
    end
    if (link_state !== s) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, link_state, s);
      end_sim();
    end
  endtask
  // Either running disparity is accepted, so the checks do not model it
  function automatic logic in2(input logic [9:0] v, input logic [9:0] a, input logic [9:0] b);
    return v === a || v === b;
  endfunction
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    samples.conv[0] <= 16'h0303;
    samples.conv[1] <= 16'h0003;
    rd(JTF_ADDR_CTRL, 32'h00001F00);
    rd(JTF_ADDR_MAP, 32'h000000E4);
    rd(8'h10, 32'h00000000);
    rd(JTF_ADDR_FCHK, 32'h000000A6);
    @(posedge clk);
    serializer_ready <= 1'b1;
    wait_for(JTF_ST_TOGGLE, 20);
    @(posedge clk);
    #1;
    `CHK({lanes[0].active, lanes[1].active, lanes[0].count}, 6'h28)
    // Reconfigure only while the link is held off
    wr(JTF_ADDR_CTRL, 32'h00001F0D);
    wait_for(JTF_ST_OFF, 10);
    rd(JTF_ADDR_CTRL, 32'h00001F09);
    wr(JTF_ADDR_CTRL, 32'h00001F05);
    wr(JTF_ADDR_MAP, 32'h000000E1);
    rd(JTF_ADDR_MAP, 32'h000000E1);
    rd(JTF_ADDR_FCHK, 32'h000000A3);
    wr(JTF_ADDR_CTRL, 32'h00001F04);
    wait_for(JTF_ST_DATA, 2000);
    repeat (40) @(posedge clk);
    #1;
    `CHK(in2(lanes[0].sym[0], 10'h274, 10'h18B), 1'b1)
    `CHK(in2(lanes[0].sym[1], 10'h31B, 10'h314), 1'b1)
    `CHK(in2(lanes[0].sym[3], 10'h0F8, 10'h307) || in2(lanes[0].sym[3], 10'h0F3, 10'h30C), 1'b1)
    `CHK(lanes[1].count, 4'h4)
    `CHK(lanes[2].active, 1'b0)
    @(posedge clk);
    resync <= 1'b1;
    @(posedge clk);
    resync <= 1'b0;
    wait_for(JTF_ST_CGS, 600);
    wait_for(JTF_ST_DATA, 3000);
    // Scrambler starts from zero, so the first data frame's last octet is known
    wr(JTF_ADDR_CTRL, 32'h00001F07);
    resync <= 1'b1;
    @(posedge clk);
    resync <= 1'b0;
    wr(JTF_ADDR_CTRL, 32'h00001F06);
    wait_for(JTF_ST_ILAS, 3000);
    @(posedge clk);
    #1;
    `CHK(in2(lanes[0].sym[0], 10'h0F4, 10'h30B), 1'b1)
    wait_for(JTF_ST_DATA, 300);
    @(posedge clk);
    #1;
    `CHK(in2(lanes[0].sym[3], 10'h25B, 10'h254), 1'b1)
    @(posedge clk);
    serializer_ready <= 1'b0;
    wait_for(JTF_ST_OFF, 10);
    end_sim();
  end
endmodule
